// *** bench/alcu_seq_model.sv ***
// Sequencer model that issues decoded instructions and samples the condition output
`timescale 1ns/10ps

module alcu_seq_model (
  input wire logic clk_sys,
  input wire logic condOut,
  input wire logic carryFlag,
  output logic instValid,
  output alcu_pkg::alcu_inst_t inst
);
  // ----------------------------------------
  // Issue and sample
  // ----------------------------------------
  logic sampCond;
  logic sampCarry;

  // Idle at time zero
  initial begin
    instValid = 1'b0;
    inst = '0;
  end

  // Issues a run back to back, one per cycle; called just after a rising edge
  task automatic run(input alcu_pkg::alcu_inst_t q[$]);
    foreach (q[k]) begin
      instValid <= 1'b1;
      inst <= q[k];
      @(posedge clk_sys);
    end
    // Idle fields carry the inverse so a stale decode cannot pass unnoticed
    instValid <= 1'b0;
    inst <= alcu_pkg::alcu_inst_t'(~q[q.size() - 1]);
    // Condition trusted only once the executing cycle has closed
    @(posedge clk_sys);
    sampCond = condOut;
    sampCarry = carryFlag;
  endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the arithmetic/logic/condition unit
`timescale 1ns/10ps
`include "alcu_defs.svh"

module testbench;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instValid, condOut, carryFlag;
  alcu_pkg::alcu_inst_t inst;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] modelGpr [32];
  logic modelCarry = 1'b0;
  logic modelCond = 1'b0;
  int errors = 0, cmp_count = 0, cycles = 0, seed = 36393;
  // Roughly 110 runs of some 32 cycles each, with wide margin
  localparam int LIMIT = 40000;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  alcu_arith_logic_unit u_alcu_arith_logic_unit (.clk_sys(clk_sys), .rst(rst), .instValid(instValid), .inst(inst),
    .condOut(condOut), .carryFlag(carryFlag), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  alcu_seq_model u_alcu_seq_model (.clk_sys(clk_sys), .condOut(condOut), .carryFlag(carryFlag),
    .instValid(instValid), .inst(inst));

  // ----------------------------------------
  // Compare, report and bus tasks
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] expv, input logic [31:0] got);
    cmp_count++;
    if (got !== expv) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, expv, got);
    end
  endtask

  task automatic chk_bit(input logic expv, input logic got);
    cmp_count++;
    if (got !== expv) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, expv, got);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard: counts as a mismatch, then reports
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles >= LIMIT) begin
      errors = errors + 1;
      complete_run();
    end
  end

  // Address and data offered together, each released on its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expResp);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      // Released payload shows its inverse, never a lingering copy
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    chk_word({30'h0, expResp}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic set_reg(input logic [4:0] idx, input logic [31:0] v);
    axi_wr(`ALCU_OFF_INDEX, {27'h0, idx}, `ALCU_RESP_OKAY);
    axi_wr(`ALCU_OFF_DATA, v, `ALCU_RESP_OKAY);
    modelGpr[idx] = v;
  endtask

  task automatic check_reg(input logic [4:0] idx);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(`ALCU_OFF_INDEX, {27'h0, idx}, `ALCU_RESP_OKAY);
    axi_rd(`ALCU_OFF_DATA, d, r);
    chk_word(modelGpr[idx], d);
  endtask

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic model_exec(input alcu_pkg::alcu_inst_t i);
    logic [31:0] a, b, x, res;
    logic [32:0] s, s31;
    logic [3:0] f;
    logic sub, cin, ovf, ge, nz, tcovf, addi;
    f = i.funcSel;
    a = modelGpr[i.firstInputIndex];
    b = modelGpr[i.secondInputIndex];
    addi = (i.opClass == alcu_pkg::ALCU_OP_ADDI10);
    if (i.opClass == alcu_pkg::ALCU_OP_LOGIC) begin
      // Each code is an inverted truth table indexed by the inverted operand bits
      for (int k = 0; k < 32; k++)
        res[k] = ~f[{~a[k], ~b[k]}];
      modelGpr[i.resultIndex] = res;
      return i.conditionSelect[0] ? (res[31:24] != 0 && res[23:16] != 0 && res[15:8] != 0 && res[7:0] != 0)
        : (res != 0);
    end
    x = addi ? {{22{i.tenBitConstant[9]}}, i.tenBitConstant}
      : (f[2] && !f[1]) ? {{27{i.shortConstant[4]}}, i.shortConstant} : b;
    sub = !addi && f[0];
    cin = (!addi && f[1] && !f[2]) ? modelCarry : sub;
    s = {1'b0, sub ? ~a : a} + {1'b0, x} + {32'h0, cin};
    s31 = {2'b0, sub ? ~a[30:0] : a[30:0]} + {2'b0, x[30:0]} + {32'h0, cin};
    tcovf = s[32] ^ s31[31];
    res = s[31:0];
    modelGpr[i.resultIndex] = res;
    if (addi)
      return tcovf;
    if (f <= 4'h3 || (f >= 4'h8 && f <= 4'hd))
      modelCarry = s[32];
    // Signed view when the upper select bits are nonzero
    ovf = (f[3:2] != 2'h0) ? tcovf : (sub ^ s[32]);
    ge = (f[3:2] != 2'h0) ? (res[31] ~^ tcovf) : (!f[0] || s[32]);
    nz = (res != 0) || ovf;
    case (i.conditionSelect)
      2'h0: return nz;
      2'h1: return ge;
      2'h2: return ovf;
      default: return nz && ge;
    endcase
  endfunction

  // Runs instructions on the design and on the model, then compares every result
  task automatic exec(input alcu_pkg::alcu_inst_t q[$]);
    logic [31:0] d;
    logic [1:0] r;
    u_alcu_seq_model.run(q);
    // Undefined class and arithmetic codes 1110/1111 must leave all state alone
    foreach (q[k]) begin
      if (q[k].opClass != 2'h2 && !(q[k].opClass == alcu_pkg::ALCU_OP_ARITH && q[k].funcSel[3:1] == 3'h7))
        modelCond = model_exec(q[k]);
    end
    chk_bit(modelCond, u_alcu_seq_model.sampCond);
    chk_bit(modelCarry, u_alcu_seq_model.sampCarry);
    axi_rd(`ALCU_OFF_STATUS, d, r);
    chk_word({30'h0, modelCond, modelCarry}, d);
    foreach (q[k])
      check_reg(q[k].resultIndex);
  endtask

  // Operands biased toward overflow and zero-byte boundaries
  function automatic logic [31:0] pick();
    logic [31:0] r;
    r = $random(seed);
    case (r[2:0])
      3'h0: return 32'h7fff_ffff;
      3'h1: return 32'h8000_0000;
      3'h2: return 32'hffff_ffff;
      3'h3: return 32'h0000_0000;
      3'h4: return 32'h00ff_0101;
      default: return $random(seed);
    endcase
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    alcu_pkg::alcu_inst_t i;
    alcu_pkg::alcu_inst_t q[$];
    logic [31:0] d;
    logic [1:0] r;
    foreach (modelGpr[k])
      modelGpr[k] = 32'h0000_0000;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk_bit(1'b0, condOut);
    chk_bit(1'b0, carryFlag);
    check_reg(5'h1f);
    // Unmapped places answer with a decode error and no data
    axi_rd(8'h0c, d, r);
    chk_word(32'h0000_0000, d);
    chk_word({30'h0, `ALCU_RESP_DECERR}, {30'h0, r});
    axi_wr(8'h10, 32'hffff_ffff, `ALCU_RESP_DECERR);
    // Every defined arithmetic code with every condition select, logic codes, ten-bit adds
    for (int op = 0; op < 3; op++) begin
      for (int f = 0; f < 16; f++) begin
        for (int c = 0; c < 4; c++) begin
          if ((op == 0 && f > 13) || (op == 1 && c > 1) || (op == 2 && f > 3))
            continue;
          d = $random(seed);
          if (op == 0)
            i.opClass = alcu_pkg::ALCU_OP_ARITH;
          else if (op == 1)
            i.opClass = alcu_pkg::ALCU_OP_LOGIC;
          else
            i.opClass = alcu_pkg::ALCU_OP_ADDI10;
          i.firstInputIndex = d[4:0];
          i.secondInputIndex = d[9:5];
          i.resultIndex = d[14:10];
          i.funcSel = f[3:0];
          i.conditionSelect = c[1:0];
          i.shortConstant = d[19:15];
          i.tenBitConstant = d[29:20];
          set_reg(i.firstInputIndex, pick());
          set_reg(i.secondInputIndex, pick());
          // Condition bit of the status word is read-only, so writing it must not stick
          axi_wr(`ALCU_OFF_STATUS, {30'h0, d[31:30]}, `ALCU_RESP_OKAY);
          modelCarry = d[30];
          q = {i};
          exec(q);
        end
      end
    end
    // Back to back: second uses the first's result, then two refused codes
    set_reg(5'h01, pick());
    set_reg(5'h02, pick());
    i = '0;
    i.opClass = alcu_pkg::ALCU_OP_ARITH;
    i.funcSel = 4'h8;
    i.firstInputIndex = 5'h01;
    i.secondInputIndex = 5'h02;
    i.resultIndex = 5'h05;
    i.conditionSelect = 2'h3;
    q = {i};
    i.opClass = alcu_pkg::ALCU_OP_LOGIC;
    i.funcSel = 4'h9;
    i.firstInputIndex = 5'h05;
    i.resultIndex = 5'h06;
    i.conditionSelect = 2'h1;
    q.push_back(i);
    i.opClass = alcu_pkg::alcu_op_t'(2'h2);
    i.resultIndex = 5'h05;
    q.push_back(i);
    i.opClass = alcu_pkg::ALCU_OP_ARITH;
    i.funcSel = 4'he;
    i.resultIndex = 5'h06;
    q.push_back(i);
    exec(q);
    complete_run();
  end
endmodule

// *** verilog/alcu_arith_logic_unit.sv ***
// Arithmetic, logical and condition-generation datapath with AXI4-Lite register access
`timescale 1ns/10ps
`include "alcu_defs.svh"

module alcu_arith_logic_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instValid,
  input wire alcu_pkg::alcu_inst_t inst,
  output logic condOut,
  output logic carryFlag,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] gpr_q [32];
  logic carry_q;
  logic cond_q;
  logic [4:0] index_q;
  logic awHeld_q;
  logic [7:0] awAddr_q;
  logic wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------
  // Operand fetch and decode
  // ----------------------------------------
  logic [31:0] opA;
  logic [31:0] opB;
  logic isArith;
  logic isLogic;
  logic isAddi10;
  logic isSub;
  logic useImm;
  logic useCarry;
  logic signedMode;
  logic arithLegal;
  logic writesCarry;
  logic exec;
  logic [31:0] shortExt;
  logic [31:0] tenExt;

  // Register file read is combinational so the op finishes in one cycle
  assign opA = gpr_q[inst.firstInputIndex];
  assign opB = gpr_q[inst.secondInputIndex];
  assign isArith = (inst.opClass == alcu_pkg::ALCU_OP_ARITH);
  assign isLogic = (inst.opClass == alcu_pkg::ALCU_OP_LOGIC);
  assign isAddi10 = (inst.opClass == alcu_pkg::ALCU_OP_ADDI10);

  // Select bit 0 marks subtract, bit 2 without bit 1 the short constant, bit 1 without bit 2 carry-in
  // Codes 0110/0111 set bit 2 yet take the second register, hence the bit 1 term
  assign isSub = inst.funcSel[0];
  assign useImm = inst.funcSel[2] & ~inst.funcSel[1];
  assign useCarry = inst.funcSel[1] & ~inst.funcSel[2];
  assign signedMode = (inst.funcSel[3:2] != 2'h0);
  // Codes 1110 and 1111 are undefined; such an instruction is dropped
  assign arithLegal = (inst.funcSel[3:1] != 3'h7);
  assign writesCarry = (inst.funcSel[3:2] != 2'h1);
  assign exec = instValid & ((isArith & arithLegal) | isLogic | isAddi10);

  assign shortExt = {{28{inst.shortConstant[4]}}, inst.shortConstant[3:0]};
  assign tenExt = {{22{inst.tenBitConstant[9]}}, inst.tenBitConstant};

  // ----------------------------------------
  // Adder
  // ----------------------------------------
  logic [31:0] addX;
  logic [31:0] addY;
  logic addCin;
  logic [32:0] sum33;
  logic [31:0] low32;
  logic [31:0] sum;
  logic c32;
  logic c31;

  // Subtract feeds the inverted first operand; borrow forms use stored carry
  assign addX = (isArith & isSub) ? ~opA : opA;
  assign addY = isAddi10 ? tenExt : (useImm ? shortExt : opB);
  assign addCin = isAddi10 ? 1'b0 : (useCarry ? carry_q : isSub);
  assign sum33 = {1'b0, addX} + {1'b0, addY} + {32'h0000_0000, addCin};
  // Separate low adder gives the carry into the sign bit
  assign low32 = {1'b0, addX[30:0]} + {1'b0, addY[30:0]} + {31'h0000_0000, addCin};
  assign sum = sum33[31:0];
  assign c32 = sum33[32];
  assign c31 = low32[31];

  // ----------------------------------------
  // Arithmetic condition
  // ----------------------------------------
  logic tcOvf;
  logic usOvf;
  logic unAdd;
  logic unSub;
  logic ovf;
  logic geZero;
  logic neZero;
  logic arithCond;

  assign tcOvf = c32 ^ c31;
  assign unAdd = ~inst.funcSel[0];
  assign unSub = inst.funcSel[0];
  assign usOvf = unSub ^ c32;
  assign ovf = signedMode ? tcOvf : usOvf;
  // Folding overflow into these terms keeps compares true to the math
  assign geZero = signedMode ? ~(sum[31] ^ tcOvf) : (unAdd | c32);
  assign neZero = (sum != 32'h0000_0000) | ovf;

  // Condition chosen by the two-bit selector
  always_comb begin
    unique case (inst.conditionSelect)
      2'h0: arithCond = neZero;
      2'h1: arithCond = geZero;
      2'h2: arithCond = ovf;
      2'h3: arithCond = neZero & geZero;
    endcase
  end

  // ----------------------------------------
  // Logical unit
  // ----------------------------------------
  logic [31:0] logicRes;
  logic logicCond;
  logic allBytesNz;

  // Sixteen bitwise functions of the two source registers
  always_comb begin
    unique case (inst.funcSel)
      4'hf: logicRes = 32'h0000_0000;
      4'he: logicRes = opA & opB;
      4'hd: logicRes = opA & ~opB;
      4'hc: logicRes = opA;
      4'hb: logicRes = ~opA & opB;
      4'ha: logicRes = opB;
      4'h9: logicRes = opA ^ opB;
      4'h8: logicRes = opA | opB;
      4'h7: logicRes = ~opA & ~opB;
      4'h6: logicRes = ~(opA ^ opB);
      4'h5: logicRes = ~opB;
      4'h4: logicRes = opA | ~opB;
      4'h3: logicRes = ~opA;
      4'h2: logicRes = ~opA | opB;
      4'h1: logicRes = ~opA | ~opB;
      4'h0: logicRes = 32'hffff_ffff;
    endcase
  end

  // Byte scan lets word ops find a zero byte in packed byte data
  assign allBytesNz = (|logicRes[31:24]) & (|logicRes[23:16]) & (|logicRes[15:8]) & (|logicRes[7:0]);
  assign logicCond = inst.conditionSelect[0] ? allBytesNz : (logicRes != 32'h0000_0000);

  // ----------------------------------------
  // Result and condition selection
  // ----------------------------------------
  logic [31:0] result;
  logic condNext;

  assign result = isLogic ? logicRes : sum;
  assign condNext = isLogic ? logicCond : (isAddi10 ? tcOvf : arithCond);

  // ----------------------------------------
  // Bus write path
  // ----------------------------------------
  logic commit;
  logic [31:0] strbMask;
  logic wrMapped;

  assign s_axi_awready = ~awHeld_q & ~bvalid_q;
  assign s_axi_wready = ~wHeld_q & ~bvalid_q;
  // Bus writes wait for a free cycle so they never race an instruction
  assign commit = awHeld_q & wHeld_q & ~bvalid_q & ~instValid;
  assign strbMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  assign wrMapped = (awAddr_q == `ALCU_OFF_STATUS) | (awAddr_q == `ALCU_OFF_INDEX) |
                    (awAddr_q == `ALCU_OFF_DATA);

  // Address and data are latched independently, in either order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end else if (commit) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (commit) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Write response, decode error for unmapped offsets
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `ALCU_RESP_OKAY;
    end else if (commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= wrMapped ? `ALCU_RESP_OKAY : `ALCU_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Register window index
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      index_q <= `ALCU_INDEX_RST;
    end else if (commit & (awAddr_q == `ALCU_OFF_INDEX) & wStrb_q[0]) begin
      index_q <= wData_q[`ALCU_INDEX_MSB:0];
    end
  end

  // ----------------------------------------
  // Architectural state
  // ----------------------------------------
  // General registers: instruction result, or bus write through the window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= `ALCU_GPR_RST;
      end
    end else if (exec) begin
      gpr_q[inst.resultIndex] <= result;
    end else if (commit & (awAddr_q == `ALCU_OFF_DATA)) begin
      gpr_q[index_q] <= (gpr_q[index_q] & ~strbMask) | (wData_q & strbMask);
    end
  end

  // Carry flag: carry-writing arithmetic, otherwise software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      carry_q <= `ALCU_CARRY_RST;
    end else if (exec & isArith & writesCarry) begin
      carry_q <= c32;
    end else if (commit & (awAddr_q == `ALCU_OFF_STATUS) & wStrb_q[0]) begin
      carry_q <= wData_q[`ALCU_STATUS_CARRY_BIT];
    end
  end

  // Condition is held until the next condition-generating instruction
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cond_q <= `ALCU_COND_RST;
    end else if (exec) begin
      cond_q <= condNext;
    end
  end
  assign condOut = cond_q;
  assign carryFlag = carry_q;

  // ----------------------------------------
  // Bus read path
  // ----------------------------------------
  logic [31:0] rdSel;
  logic rdMapped;

  // Read mux, unmapped offsets read zero
  always_comb begin
    rdSel = 32'h0000_0000;
    rdMapped = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'h0})
      `ALCU_OFF_STATUS: begin
        rdSel[`ALCU_STATUS_CARRY_BIT] = carry_q;
        rdSel[`ALCU_STATUS_COND_BIT] = cond_q;
      end
      `ALCU_OFF_INDEX: rdSel[`ALCU_INDEX_MSB:0] = index_q;
      `ALCU_OFF_DATA: rdSel = gpr_q[index_q];
      default: rdMapped = 1'b0;
    endcase
  end

  assign s_axi_arready = ~rvalid_q;

  // One read outstanding; data captured when the address is taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ALCU_RESP_OKAY;
    end else if (s_axi_arvalid & ~rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdSel;
      rresp_q <= rdMapped ? `ALCU_RESP_OKAY : `ALCU_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Independent reference values, computed from raw operands except refBytes, which scans logicRes
  logic [31:0] refSub;
  logic [31:0] refImmAdd;
  logic [32:0] refAddc;
  logic [4:0] resIdx;
  logic refSignedGe;
  logic refUnsGe;
  logic refAddiOvf;
  logic [31:0] refAddi;
  logic refBytes;
  logic [31:0] refAnd;
  logic [33:0] refWide;
  logic execArith;
  assign refSub = opB - opA;
  assign refImmAdd = opA + 32'($signed(inst.shortConstant));
  assign refAddc = {1'b0, opA} + {1'b0, opB} + {32'h0000_0000, carry_q};
  assign resIdx = inst.resultIndex;
  assign refWide = {{2{opA[31]}}, opA} + {{2{opB[31]}}, opB};
  assign refSignedGe = ~refWide[33];
  assign refUnsGe = (opB >= opA);
  // Own sum, so a broken adder cannot hide behind its own overflow term
  assign refAddi = opA + 32'($signed(inst.tenBitConstant));
  assign refAddiOvf = (opA[31] == inst.tenBitConstant[9]) & (refAddi[31] != opA[31]);
  assign refBytes = (logicRes[31:24] != 8'h00) && (logicRes[23:16] != 8'h00) &&
                    (logicRes[15:8] != 8'h00) && (logicRes[7:0] != 8'h00);
  assign refAnd = opA & opB;
  assign execArith = exec & isArith;

  a_sub_result: assert property (execArith && inst.funcSel == 4'h1 |=> gpr_q[$past(resIdx)] == $past(refSub))
    else $error("unsigned subtract result wrong");
  a_short_imm: assert property (execArith && inst.funcSel == 4'h4 |=> gpr_q[$past(resIdx)] == $past(refImmAdd))
    else $error("short constant add wrong");
  a_carry_addc: assert property (execArith && inst.funcSel == 4'h2 |=> carry_q == $past(refAddc[32]))
    else $error("carry-in add carry wrong");
  a_carry_kept: assert property (execArith && inst.funcSel[3:2] == 2'h1 |=> $stable(carry_q))
    else $error("carry changed by non-carry form");
  a_signed_ge: assert property (execArith && inst.funcSel == 4'h8 && inst.conditionSelect == 2'h1
    |=> condOut == $past(refSignedGe))
    else $error("signed ge condition wrong");
  a_unsigned_ge: assert property (execArith && inst.funcSel == 4'h1 && inst.conditionSelect == 2'h1
    |=> condOut == $past(refUnsGe))
    else $error("unsigned ge condition wrong");
  a_addi_ovf: assert property (exec && isAddi10 |=> condOut == $past(refAddiOvf) && $stable(carry_q))
    else $error("ten-bit add condition or carry wrong");
  a_logic_bytes: assert property (exec && isLogic && inst.conditionSelect[0] |=> condOut == $past(refBytes))
    else $error("byte scan condition wrong");
  a_logic_and: assert property (exec && isLogic && inst.funcSel == 4'he |=> gpr_q[$past(resIdx)] == $past(refAnd))
    else $error("logical and result wrong");
  a_cond_hold: assert property (!exec |=> $stable(condOut))
    else $error("condition changed without instruction");

  c_signed_ovf: cover property (execArith && signedMode && tcOvf && inst.conditionSelect == 2'h2);
  c_borrow: cover property (execArith && inst.funcSel == 4'h3 ##1 execArith && inst.funcSel == 4'hb);
  c_byte_scan: cover property (exec && isLogic && inst.conditionSelect[0] && !allBytesNz);
  c_bus_stall: cover property (awHeld_q && wHeld_q && instValid ##1 commit);

endmodule

// *** verilog/alcu_defs.svh ***
// Offsets, field positions and reset values for the arithmetic/logic/condition unit
`ifndef ALCU_DEFS_SVH
`define ALCU_DEFS_SVH

// ----------------------------------------
// Bus register byte offsets
// ----------------------------------------
`define ALCU_OFF_STATUS 8'h00
`define ALCU_OFF_INDEX 8'h04
`define ALCU_OFF_DATA 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ALCU_STATUS_CARRY_BIT 0
`define ALCU_STATUS_COND_BIT 1
`define ALCU_INDEX_MSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ALCU_CARRY_RST 1'b0
`define ALCU_COND_RST 1'b0
`define ALCU_INDEX_RST 5'h00
`define ALCU_GPR_RST 32'h0000_0000

// ----------------------------------------
// Bus response codes
// ----------------------------------------
`define ALCU_RESP_OKAY 2'h0
`define ALCU_RESP_DECERR 2'h3

`endif

// *** verilog/alcu_pkg.sv ***
// Types shared by the arithmetic/logic/condition unit
package alcu_pkg;

  // Instruction class as decoded by the sequencer
  typedef enum logic [1:0] {
    ALCU_OP_ARITH = 2'h0,
    ALCU_OP_LOGIC = 2'h1,
    ALCU_OP_ADDI10 = 2'h3
  } alcu_op_t;

  // One issued instruction, fields already split out
  typedef struct packed {
    alcu_op_t opClass;
    logic [4:0] firstInputIndex;
    logic [4:0] secondInputIndex;
    logic [4:0] resultIndex;
    logic [3:0] funcSel;
    logic [1:0] conditionSelect;
    logic [4:0] shortConstant;
    logic [9:0] tenBitConstant;
  } alcu_inst_t;

endpackage
